// ===== logic/rpb_pkg.sv
// Constants for the process-data buffer block.
// Assumes one 125 MHz clock and a plain register port with 16-bit data.
// What this block does
// R1: Host traffic passes only through the two buffers
// R2: Written byte replaces the previous cycle's byte
// R3: Unwritten bytes keep their contents
// R4: Channel one gets set length, rest channel two
// R5: User-data jobs need channel length nine or more; not checked, a job starts in any channel of two bytes or more
// R6: First and last channel bytes hold control/status
// R7: Header bits toggle, disable, select, ground, job
// R8: Byte one carries command code or data
// R9: Bytes two to four carry start address
// R10: Bytes five to seven carry byte count
// R11: Antennas stay active for follow-up seconds
// R12: Maximum tag count configurable, default 128
// R13: Presence changes after reread count, default five
// R14: Hop among enabled radio channels, default four
// R15: Each antenna enabled separately, default antenna one
// R16: User-data start offset configurable, default zero
// R17: User-data length one to sixteen, default sixteen
// R18: TID length two to twelve, default twelve
// R19: EPC length bounds EPC data, default 96
// R20: Host toggle means ready for more data
// R21: Disable bit zero activates, one deactivates
// R22: Select bit zero picks lower antenna
// R23: Ground state cancels pending job
// R24: Rising job bit starts job, same cycle
package rpb_pkg;
  // Register offsets on the plain port
  localparam logic [7:0] REG_BUF_BASE = 8'h00;
  localparam logic [7:0] REG_BUF1 = 8'h80;
  localparam logic [7:0] REG_FOLLOW = 8'h81;
  localparam logic [7:0] REG_MAXTAG = 8'h82;
  localparam logic [7:0] REG_REREAD = 8'h83;
  localparam logic [7:0] REG_CHANEN = 8'h84;
  localparam logic [7:0] REG_ANTEN = 8'h85;
  localparam logic [7:0] REG_USTART = 8'h86;
  localparam logic [7:0] REG_ULEN = 8'h87;
  localparam logic [7:0] REG_TIDLEN = 8'h88;
  localparam logic [7:0] REG_EPCLEN = 8'h89;
  localparam logic [7:0] REG_STATUS = 8'h8A;
  localparam logic [7:0] REG_CYCLE = 8'h8B;
  // Reset values and range limits
  localparam logic [7:0] BUF1_RST = 8'h10;
  localparam logic [7:0] FOLLOW_S_RST = 8'h05;
  localparam logic [15:0] MAXTAG_RST = 16'h0080;
  localparam logic [7:0] REREAD_RST = 8'h05;
  localparam logic [15:0] CHANEN_RST = 16'h0010;
  localparam logic [3:0] CHAN_RST = 4'h4;
  localparam logic [3:0] ANTEN_RST = 4'h1;
  localparam logic [15:0] USTART_RST = 16'h0000;
  localparam logic [4:0] ULEN_RST = 5'h10;
  localparam logic [4:0] ULEN_MIN = 5'h01;
  localparam logic [4:0] ULEN_MAX = 5'h10;
  localparam logic [3:0] TID_RST = 4'hC;
  localparam logic [3:0] TID_MIN = 4'h2;
  localparam logic [3:0] TID_MAX = 4'hC;
  localparam logic [8:0] EPC_RST = 9'h060;
  localparam logic [8:0] EPC_MAX = 9'h1F0;
  // Output header bit positions
  localparam int unsigned HB_TOGGLE = 6;
  localparam int unsigned HB_DISABLE = 5;
  localparam int unsigned HB_SELECT = 4;
  localparam int unsigned HB_GROUND = 2;
  localparam int unsigned HB_JOB = 0;
  // Input status bit positions
  localparam int unsigned SB_READY = 7;
  localparam int unsigned SB_ANTERR = 6;
  localparam int unsigned SB_TOGGLE = 5;
  localparam int unsigned SB_ANT = 4;
  localparam int unsigned SB_JOBERR = 3;
  localparam int unsigned SB_JOBEND = 2;
  localparam int unsigned SB_JOBSTART = 1;
  localparam int unsigned SB_PRESENT = 0;
  // Timing
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned HOP_MS = 400;
  localparam int unsigned HOP_CYC_DEF = HOP_MS * (CLK_HZ / 1000);
  // Job state per channel
  typedef enum logic [1:0]
  {
    JOB_IDLE = 2'b00,
    JOB_RUN = 2'b01,
    JOB_END = 2'b10,
    JOB_FAIL = 2'b11
  } rpb_job_t;
endpackage : rpb_pkg

// ===== logic/rpb_presence.sv
// Debounce of tag presence for one antenna.
// Assumes hit and miss are one-cycle pulses from the air interface.
module rpb_presence
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic hit,
  input wire logic miss,
  input wire logic [7:0] threshold,
  output logic present
);
  logic [7:0] cnt_q;
  logic [7:0] thr;
  logic toChange;
  logic count;

  // A zero threshold behaves as one
  assign thr = (threshold == 8'h00) ? 8'h01 : threshold;
  assign count = present ? miss : hit;
  assign toChange = count && ((cnt_q + 8'h01) >= thr);

  // Consecutive rereads flip the reported state
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_q <= 8'h00;
      present <= 1'b0;
    end
    else if (toChange)
    begin
      cnt_q <= 8'h00;
      present <= !present; // [R13]
    end
    else if (count)
      cnt_q <= cnt_q + 8'h01; // [R13]
    else if (present ? hit : miss)
      cnt_q <= 8'h00;
  end
endmodule : rpb_presence

// ===== logic/rpb_follow_timer.sv
// Follow-up timer that holds antennas on for whole seconds.
// Assumes CYC_PER_SEC clock cycles make one second.
module rpb_follow_timer
#(
  parameter int unsigned CYC_PER_SEC = 125_000_000
)
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic start,
  input wire logic cancel,
  input wire logic [7:0] seconds,
  output logic active
);
  localparam int unsigned PW = $clog2(CYC_PER_SEC + 1);
  localparam logic [PW-1:0] PRE_LAST = PW'(CYC_PER_SEC - 1);
  logic [PW-1:0] pre_q;
  logic [7:0] sec_q;

  if (CYC_PER_SEC < 2)
  begin : g_bad_cyc
    $error("CYC_PER_SEC must be at least 2");
  end

  assign active = (sec_q != 8'h00);

  // Seconds countdown with a cycle prescaler
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      pre_q <= '0;
      sec_q <= 8'h00;
    end
    else if (cancel)
    begin
      pre_q <= '0;
      sec_q <= 8'h00;
    end
    else if (start)
    begin
      pre_q <= '0;
      sec_q <= seconds; // [R11]
    end
    else if (active)
    begin
      if (pre_q == PRE_LAST)
      begin
        pre_q <= '0;
        sec_q <= sec_q - 8'h01; // [R11]
      end
      else
        pre_q <= pre_q + 1'b1;
    end
  end
endmodule : rpb_follow_timer

// ===== logic/rpb_process_buffer.sv
// Process-data buffer of the identification processor.
// Assumes the fieldbus side writes output bytes and reads input bytes
// over the register port and marks each poll cycle by a commit write.
//
// Our own choices: strobed register access and the register offsets.
module rpb_process_buffer
  import rpb_pkg::*;
#(
  parameter int unsigned TOTAL = 64,
  parameter int unsigned CYC_PER_SEC = CLK_HZ,
  parameter int unsigned HOP_CYC = HOP_CYC_DEF
)
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [7:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  output logic [15:0] regRdData,
  output logic [1:0] jobStart,
  output logic [1:0] jobCancel,
  output logic [1:0][7:0] jobCmd,
  output logic [1:0][23:0] jobAddr,
  output logic [1:0][23:0] jobCount,
  output logic [1:0] jobSelect,
  output logic [1:0][7:0] chanDataLen,
  output logic [1:0] hostToggle,
  input wire logic [1:0] jobDone,
  input wire logic [1:0] jobFail,
  input wire logic [1:0] devToggle,
  input wire logic inWrEn,
  input wire logic [7:0] inWrAddr,
  input wire logic [7:0] inWrData,
  input wire logic [3:0] antErr,
  input wire logic [3:0] tagHit,
  input wire logic [3:0] tagMiss,
  output logic [3:0] tagPresent,
  output logic [3:0] antActive,
  output logic [3:0] rfChannel,
  output logic [15:0] maxTags,
  output logic [15:0] userStart,
  output logic [4:0] userLen,
  output logic [3:0] tidLen,
  output logic [8:0] epcLen
);
  localparam int unsigned AW = $clog2(TOTAL);
  localparam logic [7:0] TOTAL8 = 8'(TOTAL);
  localparam int unsigned HW = $clog2(HOP_CYC + 1);
  localparam logic [HW-1:0] HOP_LAST = HW'(HOP_CYC - 1);

  if (TOTAL < 4 || TOTAL > 128 || HOP_CYC < 2)
  begin : g_bad_param
    $error("TOTAL must lie in 4..128 and HOP_CYC be at least 2");
  end

  // Buffers, configuration and per-channel state
  logic [7:0] outBuf [TOTAL];
  logic [7:0] inBuf [TOTAL];
  logic [7:0] buf1_q;
  logic [7:0] follow_q;
  logic [7:0] reread_q;
  logic [15:0] chanEn_q;
  logic [3:0] antEn_q;
  logic [1:0][7:0] hdr_q;
  logic [1:0] jobReq_q;
  rpb_job_t [1:0] job_q;
  logic [HW-1:0] hop_q;
  logic [1:0] timerOn;
  logic [1:0][7:0] base;
  logic [1:0][7:0] len;
  logic [1:0][7:0] newHdr;
  logic [1:0] hdrOk;
  logic [1:0] startD;
  logic [1:0] groundD;
  logic wrBuf;
  logic commit;
  logic [7:0] rdByte;
  logic [15:0] rdWord;

  assign wrBuf = regWrStb && (regAddr < TOTAL8);
  assign commit = regWrStb && (regAddr == REG_CYCLE);

  // Channel geometry from the split parameter
  assign base[0] = 8'h00;
  assign len[0] = buf1_q; // [R4]
  assign base[1] = buf1_q;
  assign len[1] = TOTAL8 - buf1_q; // [R4]

  // Reads a byte of the output buffer with the index kept in range
  function automatic logic [7:0] outAt(input logic [7:0] idx);
    outAt = (idx < TOTAL8) ? outBuf[idx[AW-1:0]] : 8'h00;
  endfunction : outAt

  // Header decode at each poll cycle boundary
  always_comb
  begin
    for (int c = 0; c < 2; c++)
    begin
      newHdr[c] = outAt(base[c]); // [R7]
      // Header counts only when the trailing copy matches it
      hdrOk[c] = commit && (len[c] >= 8'h02) &&
        (newHdr[c] == outAt(base[c] + len[c] - 8'h01)); // [R6] [R7]
      groundD[c] = hdrOk[c] && newHdr[c][HB_GROUND]; // [R23]
      startD[c] = hdrOk[c] && !groundD[c] && newHdr[c][HB_JOB] &&
        !jobReq_q[c]; // [R24]
    end
  end

  // Output buffer: a write replaces only the addressed byte
  always_ff @(posedge clk_sys)
  begin
    if (wrBuf)
      outBuf[regAddr[AW-1:0]] <= regWrData[7:0]; // [R1] [R2] [R3]
  end

  // Input buffer data bytes come from the job engine and persist
  always_ff @(posedge clk_sys)
  begin
    if (inWrEn && (inWrAddr < TOTAL8))
      inBuf[inWrAddr[AW-1:0]] <= inWrData; // [R1] [R3]
  end

  // Configuration registers with range limits
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      buf1_q <= BUF1_RST;
      follow_q <= FOLLOW_S_RST;
      maxTags <= MAXTAG_RST;
      reread_q <= REREAD_RST;
      chanEn_q <= CHANEN_RST;
      antEn_q <= ANTEN_RST;
      userStart <= USTART_RST;
      userLen <= ULEN_RST;
      tidLen <= TID_RST;
      epcLen <= EPC_RST;
    end
    else if (regWrStb)
    begin
      unique case (regAddr)
        REG_BUF1:
          buf1_q <= (regWrData[7:0] > TOTAL8) ? TOTAL8
            : regWrData[7:0]; // [R4]
        REG_FOLLOW:
          follow_q <= regWrData[7:0]; // [R11]
        REG_MAXTAG:
          maxTags <= regWrData; // [R12]
        REG_REREAD:
          reread_q <= regWrData[7:0]; // [R13]
        REG_CHANEN:
          chanEn_q <= regWrData; // [R14]
        REG_ANTEN:
          antEn_q <= regWrData[3:0]; // [R15]
        REG_USTART:
          userStart <= regWrData; // [R16]
        REG_ULEN:
          if (regWrData < 16'(ULEN_MIN))
            userLen <= ULEN_MIN; // [R17]
          else if (regWrData > 16'(ULEN_MAX))
            userLen <= ULEN_MAX; // [R17]
          else
            userLen <= regWrData[4:0];
        REG_TIDLEN:
          if (regWrData < 16'(TID_MIN))
            tidLen <= TID_MIN; // [R18]
          else if (regWrData > 16'(TID_MAX))
            tidLen <= TID_MAX; // [R18]
          else
            tidLen <= regWrData[3:0];
        REG_EPCLEN:
          epcLen <= (regWrData > 16'(EPC_MAX)) ? EPC_MAX
            : regWrData[8:0]; // [R19]
        default:
        begin
        end
      endcase
    end
  end

  // Latched header and job request level per channel
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      hdr_q <= '0;
      jobReq_q <= 2'b00;
    end
    else
    begin
      for (int c = 0; c < 2; c++)
      begin
        if (hdrOk[c])
        begin
          hdr_q[c] <= newHdr[c];
          jobReq_q[c] <= newHdr[c][HB_JOB] && !groundD[c]; // [R24]
        end
      end
    end
  end

  // Job parameters taken from the same cycle as the job edge
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      jobCmd <= '0;
      jobAddr <= '0;
      jobCount <= '0;
      jobSelect <= 2'b00;
    end
    else
    begin
      for (int c = 0; c < 2; c++)
      begin
        if (startD[c])
        begin
          jobCmd[c] <= outAt(base[c] + 8'h01); // [R8] [R24]
          jobAddr[c] <= {outAt(base[c] + 8'h04),
            outAt(base[c] + 8'h03), outAt(base[c] + 8'h02)}; // [R9]
          jobCount[c] <= {outAt(base[c] + 8'h07),
            outAt(base[c] + 8'h06), outAt(base[c] + 8'h05)}; // [R10]
          jobSelect[c] <= newHdr[c][HB_SELECT]; // [R22]
        end
      end
    end
  end

  // Job pulses toward the engine
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      jobStart <= 2'b00;
      jobCancel <= 2'b00;
    end
    else
    begin
      jobStart <= startD; // [R24]
      jobCancel <= groundD; // [R23]
    end
  end

  // Job state machine per channel
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      job_q <= '{JOB_IDLE, JOB_IDLE};
    else
    begin
      for (int c = 0; c < 2; c++)
      begin
        if (groundD[c])
          job_q[c] <= (job_q[c] == JOB_RUN) ? JOB_FAIL
            : JOB_IDLE; // [R23]
        else if (startD[c])
          job_q[c] <= JOB_RUN; // [R24]
        else
        begin
          unique case (job_q[c])
            JOB_IDLE:
              job_q[c] <= JOB_IDLE;
            JOB_RUN:
              if (jobFail[c])
                job_q[c] <= JOB_FAIL;
              else if (jobDone[c])
                job_q[c] <= JOB_END;
            JOB_END, JOB_FAIL:
              // Acknowledge clears once the host drops its request
              if (hdrOk[c] && !newHdr[c][HB_JOB])
                job_q[c] <= JOB_IDLE;
          endcase
        end
      end
    end
  end

  // Follow-up timers, one per channel
  for (genvar c = 0; c < 2; c++)
  begin : g_timer
    rpb_follow_timer #(
      .CYC_PER_SEC(CYC_PER_SEC)
    ) u_timer (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .start(startD[c]),
      .cancel(groundD[c]),
      .seconds(follow_q),
      .active(timerOn[c])
    );
  end

  // Presence filters, one per antenna
  for (genvar a = 0; a < 4; a++)
  begin : g_pres
    rpb_presence u_pres (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .hit(tagHit[a] && antActive[a]),
      .miss(tagMiss[a] && antActive[a]),
      .threshold(reread_q),
      .present(tagPresent[a])
    );
  end

  // Antenna drive: enabled, selected, not disabled, timer running
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      antActive <= 4'h0;
    else
    begin
      for (int a = 0; a < 4; a++)
        antActive[a] <= antEn_q[a] && timerOn[a % 2] &&
          (hdr_q[a % 2][HB_SELECT] == (a >= 2)) && // [R22]
          !hdr_q[a % 2][HB_DISABLE]; // [R11] [R15] [R21]
    end
  end

  // Host toggle level handed to the engine
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      hostToggle <= 2'b00;
    else
    begin
      for (int c = 0; c < 2; c++)
        hostToggle[c] <= hdr_q[c][HB_TOGGLE]; // [R20]
    end
  end

  // Channel hopping among the enabled radio channels
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      hop_q <= '0;
      rfChannel <= CHAN_RST;
    end
    else if (hop_q == HOP_LAST || !chanEn_q[rfChannel])
    begin
      hop_q <= '0;
      for (int k = 15; k >= 1; k--)
      begin
        if (chanEn_q[4'(rfChannel + 4'(k))])
          rfChannel <= 4'(rfChannel + 4'(k)); // [R14]
      end
    end
    else
      hop_q <= hop_q + 1'b1;
  end

  // Usable data bytes per channel
  always_comb
  begin
    for (int c = 0; c < 2; c++)
      chanDataLen[c] = (len[c] > 8'h02) ? len[c] - 8'h02 : 8'h00; // [R6]
  end

  // Status byte and input-buffer byte seen at the read address
  always_comb
  begin
    logic ch;
    logic [7:0] off;
    logic [1:0] ant;
    ch = (regAddr >= buf1_q);
    off = regAddr - base[ch];
    ant = {hdr_q[ch][HB_SELECT], ch};
    if (off == 8'h00 || off == len[ch] - 8'h01)
    begin
      rdByte = 8'h00; // [R6] [R7]
      rdByte[SB_READY] = 1'b1;
      rdByte[SB_ANTERR] = antErr[ant];
      rdByte[SB_TOGGLE] = devToggle[ch];
      rdByte[SB_ANT] = hdr_q[ch][HB_SELECT];
      rdByte[SB_JOBERR] = (job_q[ch] == JOB_FAIL);
      rdByte[SB_JOBEND] = (job_q[ch] == JOB_END);
      rdByte[SB_JOBSTART] = (job_q[ch] != JOB_IDLE);
      rdByte[SB_PRESENT] = tagPresent[ant];
    end
    else
      rdByte = inBuf[regAddr[AW-1:0]];
  end

  // Register read multiplexer
  always_comb
  begin
    rdWord = 16'h0000;
    if (regAddr < TOTAL8)
      rdWord = {8'h00, rdByte}; // [R1]
    else
    begin
      unique case (regAddr)
        REG_BUF1: rdWord = {8'h00, buf1_q};
        REG_FOLLOW: rdWord = {8'h00, follow_q};
        REG_MAXTAG: rdWord = maxTags;
        REG_REREAD: rdWord = {8'h00, reread_q};
        REG_CHANEN: rdWord = chanEn_q;
        REG_ANTEN: rdWord = {12'h000, antEn_q};
        REG_USTART: rdWord = userStart;
        REG_ULEN: rdWord = {11'h000, userLen};
        REG_TIDLEN: rdWord = {12'h000, tidLen};
        REG_EPCLEN: rdWord = {7'h00, epcLen};
        REG_STATUS:
          rdWord = {job_q[1], job_q[0], rfChannel, antActive, tagPresent};
        default: rdWord = 16'h0000;
      endcase
    end
  end

  // Read data stands one cycle after the strobe only
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      regRdData <= 16'h0000;
    else if (regRdStb)
      regRdData <= rdWord;
    else
      regRdData <= 16'h0000;
  end
endmodule : rpb_process_buffer

// ===== dv/rpb_process_buffer_props.sv
// Checker for the process buffer top ports.
// Assumes one clock domain with an asynchronous active-low reset.
module rpb_process_buffer_props
  import rpb_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [7:0] regAddr,
  input wire logic regWrStb,
  input wire logic regRdStb,
  input wire logic [15:0] regRdData,
  input wire logic [1:0] jobStart,
  input wire logic [1:0] jobCancel,
  input wire logic [1:0][7:0] jobCmd,
  input wire logic [1:0][23:0] jobAddr,
  input wire logic [3:0] tagHit,
  input wire logic [3:0] tagPresent,
  input wire logic [3:0] antActive,
  input wire logic [4:0] userLen,
  input wire logic [3:0] tidLen,
  input wire logic [8:0] epcLen
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  // Read data and job pulses tied to their causes
  a_rd_data_idle: assert property (!$past(regRdStb) |->
    regRdData == 16'h0)
    else $error("read data outside answer cycle");
  a_start_one_pulse: assert property (jobStart[0] |=> !jobStart[0])
    else $error("job start longer than one cycle");
  a_start_from_commit: assert property (jobStart[1] |->
    $past(regWrStb && regAddr == REG_CYCLE))
    else $error("job start without commit");
  a_cancel_from_commit: assert property (jobCancel[0] |->
    $past(regWrStb && regAddr == REG_CYCLE))
    else $error("cancel without commit");
  a_job_fields_hold: assert property (!jobStart[0] |->
    $stable(jobCmd[0]) && $stable(jobAddr[0]))
    else $error("job fields moved without start");
  // Configuration ranges, presence after a hit and covers
  a_user_len_range: assert property (userLen inside {[5'h01:5'h10]})
    else $error("user length out of range");
  a_tid_len_range: assert property (tidLen inside {[4'h2:4'hC]})
    else $error("tid length out of range");
  a_epc_len_bound: assert property (epcLen <= 9'h1F0)
    else $error("epc length above bound");
  a_present_after_hit: assert property ($rose(tagPresent[0]) |->
    $past(tagHit[0]) || $past(tagHit[0], 2))
    else $error("presence rose without hit");
  c_job_start: cover property (jobStart[0]);
  c_cancel: cover property (jobCancel[0]);
  c_present: cover property (tagPresent[0] && antActive[0]);
endmodule : rpb_process_buffer_props

bind rpb_process_buffer rpb_process_buffer_props rpb_process_buffer_props_inst
(
  .clk_sys(clk_sys), .nrst(nrst), .regAddr(regAddr), .regWrStb(regWrStb),
  .regRdStb(regRdStb), .regRdData(regRdData), .jobStart(jobStart),
  .jobCancel(jobCancel), .jobCmd(jobCmd), .jobAddr(jobAddr),
  .tagHit(tagHit), .tagPresent(tagPresent), .antActive(antActive),
  .userLen(userLen), .tidLen(tidLen), .epcLen(epcLen)
);

// ===== dv/rpb_engine_model.sv
// Job engine model facing the job ports of the process buffer.
// Assumes one job at a time and channel two based at byte 16.
module rpb_engine_model
#(
  parameter int unsigned DLY = 4
)
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [1:0] jobStart,
  input wire logic [1:0][7:0] jobCmd,
  input wire logic [1:0] hostToggle,
  output logic [1:0] jobDone,
  output logic [1:0] jobFail,
  output logic [1:0] devToggle,
  output logic inWrEn,
  output logic [7:0] inWrAddr,
  output logic [7:0] inWrData
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt [2];
  assign jobFail = 2'b00;
  // Count each job down, echo its command, report the end
  always @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt <= '{0, 0};
      {jobDone, devToggle, inWrEn, inWrAddr, inWrData} <= '0;
    end
    else
    begin
      jobDone <= 2'b00;
      inWrEn <= 1'b0;
      inWrData <= ~inWrData; // No stale byte while idle
      devToggle <= hostToggle; // Ready for more data
      for (int c = 0; c < 2; c++)
      begin
        if (jobStart[c])
          cnt[c] <= DLY;
        else if (cnt[c] == 1)
        begin
          cnt[c] <= 0;
          inWrEn <= 1'b1; // Answer through input buffer
          inWrAddr <= (c == 0) ? 8'h01 : 8'h11;
          inWrData <= jobCmd[c];
          jobDone[c] <= 1'b1;
        end
        else if (cnt[c] > 1)
          cnt[c] <= cnt[c] - 1;
      end
    end
  end
endmodule : rpb_engine_model

// ===== dv/tb_top.sv
// Bench driving the process buffer over its register port.
// Assumes ten cycles per second and an eight cycle hop period.
module tb_top
  import rpb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [15:0] regWrData = 16'h0000;
  logic regWrStb = 1'b0;
  logic regRdStb = 1'b0;
  logic [3:0] antErr = 4'h1;
  logic [3:0] tagHit = 4'h0;
  logic [3:0] tagMiss = 4'h0;
  logic [15:0] regRdData, maxTags, userStart, rdVal;
  logic [1:0] jobStart, jobCancel, jobSelect, hostToggle;
  logic [1:0] jobDone, jobFail, devToggle;
  logic [1:0][7:0] jobCmd, chanDataLen;
  logic [1:0][23:0] jobAddr, jobCount;
  logic inWrEn, seen;
  logic [7:0] inWrAddr, inWrData;
  logic [3:0] tagPresent, antActive, rfChannel, tidLen;
  logic [4:0] userLen;
  logic [8:0] epcLen;
  int n_mismatch = 0;
  int checks_done = 0;
  int cyc = 0;
  int nSt [2] = '{0, 0};
  int nCa = 0;
  localparam logic [7:0] RA [8] = '{REG_BUF1, REG_FOLLOW, REG_REREAD,
    REG_CHANEN, REG_ANTEN, REG_USTART, 8'h8C, 8'h40};
  localparam logic [15:0] RE [8] = '{16'h0010, 16'h0005, 16'h0005,
    16'h0010, 16'h0001, 16'h0000, 16'h0000, 16'h0000};
  localparam logic [7:0] CA [5] = '{REG_ULEN, REG_ULEN, REG_TIDLEN,
    REG_TIDLEN, REG_EPCLEN};
  localparam logic [15:0] CW [5] = '{16'h0000, 16'h0014, 16'h0001,
    16'h000D, 16'h01F4};
  localparam logic [15:0] CE [5] = '{16'h0001, 16'h0010, 16'h0002,
    16'h000C, 16'h01F0};
  always #4 clk_sys = ~clk_sys;
  rpb_process_buffer #(.TOTAL(64), .CYC_PER_SEC(10), .HOP_CYC(8))
    rpb_process_buffer_inst (.clk_sys(clk_sys), .nrst(nrst),
    .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb),
    .regRdStb(regRdStb), .regRdData(regRdData), .jobStart(jobStart),
    .jobCancel(jobCancel), .jobCmd(jobCmd), .jobAddr(jobAddr),
    .jobCount(jobCount), .jobSelect(jobSelect), .chanDataLen(chanDataLen),
    .hostToggle(hostToggle), .jobDone(jobDone), .jobFail(jobFail),
    .devToggle(devToggle), .inWrEn(inWrEn), .inWrAddr(inWrAddr),
    .inWrData(inWrData), .antErr(antErr), .tagHit(tagHit),
    .tagMiss(tagMiss), .tagPresent(tagPresent), .antActive(antActive),
    .rfChannel(rfChannel), .maxTags(maxTags), .userStart(userStart),
    .userLen(userLen), .tidLen(tidLen), .epcLen(epcLen));
  rpb_engine_model rpb_engine_model_inst (.clk_sys(clk_sys), .nrst(nrst),
    .jobStart(jobStart), .jobCmd(jobCmd), .hostToggle(hostToggle),
    .jobDone(jobDone), .jobFail(jobFail), .devToggle(devToggle),
    .inWrEn(inWrEn), .inWrAddr(inWrAddr), .inWrData(inWrData));
  // Pulse counters and run limit
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    nSt[0] <= nSt[0] + int'(jobStart[0]);
    nSt[1] <= nSt[1] + int'(jobStart[1]);
    nCa <= nCa + int'(jobCancel[0]);
    if (cyc == 20000)
    begin
      n_mismatch++;
      end_sim();
    end
  end
  task automatic chk(input string nm, input logic [31:0] got,
    input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("FAIL %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge clk_sys);
    regWrStb <= 1'b0;
    @(posedge clk_sys);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge clk_sys);
    regRdStb <= 1'b0;
    @(posedge clk_sys);
    rdVal = regRdData; // Answer cycle value
  endtask : rd
  // Same header at both ends of a channel, then a poll commit
  task automatic hdr(input logic [7:0] b, input logic [7:0] l,
    input logic [7:0] h);
    wr(b, {8'h00, h});
    wr(l, {8'h00, h});
    wr(REG_CYCLE, 16'h0000);
  endtask : hdr
  task automatic cyc_wait(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc_wait
  task automatic pulse(input logic hit);
    tagHit <= {3'b000, hit};
    tagMiss <= {3'b000, !hit};
    @(posedge clk_sys);
    tagHit <= 4'h0;
    tagMiss <= 4'h0;
    @(posedge clk_sys);
  endtask : pulse
  task automatic end_sim();
    if (n_mismatch == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim
  // Main sequence
  initial
  begin
    cyc_wait(12);
    nrst <= 1'b1;
    @(posedge clk_sys);
    chk("maxTags", maxTags, 32'h80);
    chk("lens", {userLen, tidLen, epcLen}, 32'h21860);
    chk("rfChannel", rfChannel, 32'h4);
    chk("chanDataLen", chanDataLen, 32'h2E0E);
    for (int i = 0; i < 8; i++)
    begin
      rd(RA[i]);
      chk("reg reset", rdVal, RE[i]);
    end
    for (int i = 1; i < 8; i++)
      wr(8'(i), 16'(8'h0 + (i < 5 ? i : (i == 5 ? 16 : 0))));
    hdr(8'h00, 8'h0F, 8'h41); // User-data job in a 16-byte channel
    cyc_wait(2);
    chk("start", nSt[0], 1);
    chk("job0", {jobCmd[0], jobAddr[0]}, 32'h01040302);
    chk("count0", jobCount[0], 32'h10);
    chk("toggle", hostToggle[0], 1);
    wr(REG_CYCLE, 16'h0000);
    cyc_wait(6);
    chk("no restart", nSt[0], 1);
    rd(8'h00);
    chk("status", rdVal, 16'hE6);
    rd(8'h01);
    chk("answer", rdVal & 16'h00FF, 16'h01);
    rd(REG_STATUS);
    chk("job end", rdVal[13:12], 2'b10);
    hdr(8'h00, 8'h0F, 8'h00);
    wr(8'h01, 16'h0003);
    hdr(8'h00, 8'h0F, 8'h41);
    cyc_wait(2);
    chk("rewrite", {jobCmd[0], jobAddr[0]}, 32'h03040302);
    hdr(8'h00, 8'h0F, 8'h00);
    wr(8'h00, 16'h0001);
    wr(REG_CYCLE, 16'h0000);
    cyc_wait(2);
    chk("bad trailer", nSt[0], 2);
    hdr(8'h00, 8'h0F, 8'h04);
    cyc_wait(2);
    chk("cancel", nCa, 1);
    hdr(8'h00, 8'h0F, 8'h00);
    hdr(8'h00, 8'h0F, 8'h01);
    cyc_wait(4);
    chk("ant on", antActive, 4'h1);
    cyc_wait(30);
    chk("ant held", antActive, 4'h1);
    cyc_wait(40);
    chk("ant off", antActive, 4'h0);
    wr(REG_ANTEN, 16'h0005);
    hdr(8'h00, 8'h0F, 8'h00);
    hdr(8'h00, 8'h0F, 8'h11);
    cyc_wait(4);
    chk("ant three", {jobSelect[0], antActive}, 5'h14);
    hdr(8'h00, 8'h0F, 8'h00);
    hdr(8'h00, 8'h0F, 8'h31);
    cyc_wait(4);
    chk("ant disabled", antActive, 4'h0);
    wr(REG_REREAD, 16'h0002);
    hdr(8'h00, 8'h0F, 8'h00);
    hdr(8'h00, 8'h0F, 8'h01);
    pulse(1'b1);
    pulse(1'b1);
    cyc_wait(2);
    chk("present", tagPresent[0], 1);
    pulse(1'b0);
    cyc_wait(2);
    chk("still present", tagPresent[0], 1);
    pulse(1'b0);
    cyc_wait(2);
    chk("gone", tagPresent[0], 0);
    wr(8'h11, 16'h0055);
    hdr(8'h10, 8'h3F, 8'h01);
    cyc_wait(2);
    chk("chan two", {nSt[1][7:0], jobCmd[1]}, 16'h0155);
    for (int i = 0; i < 5; i++)
    begin
      wr(CA[i], CW[i]);
      rd(CA[i]);
      chk("clamp", rdVal, CE[i]);
    end
    wr(REG_MAXTAG, 16'h0010);
    wr(REG_USTART, 16'h0020);
    chk("cfg ports", {maxTags, userStart}, 32'h00100020);
    wr(REG_CHANEN, 16'h0090);
    seen = 1'b0;
    repeat (40)
    begin
      @(posedge clk_sys);
      if (rfChannel === 4'h7) seen = 1'b1;
    end
    chk("hop", seen, 1);
    end_sim();
  end
endmodule : tb_top
